// ### logic/psi_pkg.sv
// shared constants for the periodic sample integrator, both ends
// assumes both ends run on one clock, ref_clk at 200 MHz
package psi_pkg;
  localparam int WORD_W = 24;
  localparam int MINOR_W = 16;
  localparam int MAJOR_W = 24;
  localparam int COUNT_W = 16;
  localparam int ADC_W = 12;
  localparam int ADDR_W = 13;
  localparam int PTR_W = 3;
  // register pointer codes carried in the control word
  localparam logic [2:0] PTR_MEM = 3'h0;
  localparam logic [2:0] PTR_MINOR = 3'h1;
  localparam logic [2:0] PTR_MAJOR = 3'h2;
  localparam logic [2:0] PTR_DELAY = 3'h3;
  localparam logic [2:0] PTR_END = 3'h4;
  localparam logic [2:0] PTR_CYCLE = 3'h5;
  localparam logic [2:0] PTR_IDLE = 3'h6;
  localparam logic [2:0] PTR_ADDR = 3'h7;
  // control word bit positions
  localparam int CTL_INC_OUT = 3;
  localparam int CTL_INC_IN = 4;
  localparam int CTL_INIT = 5;
  localparam int CTL_NEXT_CLR = 6;
  localparam int CTL_NEXT_KEEP = 7;
  // host side apb map
  localparam logic [7:0] APB_CMD = 8'h00;
  localparam logic [7:0] APB_DOUT = 8'h04;
  localparam logic [7:0] APB_DIN = 8'h08;
  localparam logic [7:0] APB_STATUS = 8'h0c;
  localparam int ST_DONE = 0;
  localparam int ST_IN_PEND = 1;
  localparam logic [23:0] RST_WORD = 24'h000000;
  typedef enum logic [1:0] {
    PSI_IDLE, PSI_WAIT_TICK, PSI_WAIT_MAJ, PSI_OBSERVE
  } psi_run_t;
endpackage

// ### logic/psi_if.sv
// word channel between the host end and the integrator end
// assumes both ends share ref_clk; strobes are one-cycle pulses
`timescale 1ns/100ps
interface psi_if;
  logic ctl_stb;
  logic out_stb;
  logic in_stb;
  logic [23:0] out_word;
  logic [23:0] in_word;
  logic in_valid;
  logic done;
  modport host(output ctl_stb, out_stb, in_stb, out_word,
               input in_word, in_valid, done);
  modport dev(input ctl_stb, out_stb, in_stb, out_word,
              output in_word, in_valid, done);
endinterface

// ### logic/psi_device.sv
// integrator end: dividers, window, cycle counter, sample memory
// assumes synth_pin and tick_pin are asynchronous pins and adc_data
// holds a settled conversion whenever a minor pulse falls
//
// The APB interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/100ps
module psi_device #(
  parameter int ADDR_W = psi_pkg::ADDR_W
) (
  input wire logic ref_clk,
  input wire logic rstn,
  psi_if.dev link,
  input wire logic synth_pin,
  input wire logic tick_pin,
  input wire logic [11:0] adc_data,
  output logic conv_start,
  output logic observing
);
  localparam int W = psi_pkg::WORD_W;
  localparam int CW = psi_pkg::COUNT_W;

  logic [2:0] syn_ff, tck_ff;
  logic syn_st_ff, tck_st_ff;
  logic syn_p, tck_p;

  logic [15:0] minor_divider_hold_ff, nxt_minor_divider_hold;
  logic [23:0] major_divider_hold_ff, nxt_major_divider_hold;
  logic [23:0] sample_start_delay_ff, nxt_sample_start_delay;
  logic [23:0] sample_window_end_ff, nxt_sample_window_end;
  logic [15:0] observe_cycle_count_ff, nxt_observe_cycle_count;
  logic [15:0] idle_cycle_count_ff, nxt_idle_cycle_count;
  logic [ADDR_W-1:0] addr_ff, nxt_addr;
  logic [2:0] ptr_ff, nxt_ptr;
  logic inc_out_ff, nxt_inc_out, inc_in_ff, nxt_inc_in;
  logic [15:0] minor_act_ff, nxt_minor_act, minor_cnt_ff, nxt_minor_cnt;
  logic [23:0] major_cnt_ff, nxt_major_cnt, win_ff, nxt_win;
  logic [15:0] cyc_ff, nxt_cyc;
  logic up_ff, nxt_up, first_ff, nxt_first;
  psi_pkg::psi_run_t run_ff, nxt_run;
  logic [23:0] sum_ff, nxt_sum;
  logic wr_pend_ff, nxt_wr_pend;
  logic [ADDR_W-1:0] wa_ff, nxt_wa;
  logic [23:0] in_word_ff, nxt_in_word;
  logic in_valid_ff, nxt_in_valid, done_ff, nxt_done;
  logic conv_ff, nxt_conv, obs_ff, nxt_obs;

  logic [W-1:0] mem [2**ADDR_W];
  logic mem_we;
  logic [ADDR_W-1:0] mem_wa;
  logic [W-1:0] mem_wd;

  function automatic logic [2:0] ptr_step(input logic [2:0] p);
    if (p == psi_pkg::PTR_ADDR) begin
      return psi_pkg::PTR_MEM;
    end
    return 3'(p + 3'h1);
  endfunction

  function automatic logic [23:0] sext(input logic [11:0] s);
    return {{12{s[11]}}, s};
  endfunction

  // pin synchronisers: a change counts once stages two and three agree
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      syn_ff <= 3'h0;
      tck_ff <= 3'h0;
      syn_st_ff <= 1'b0;
      tck_st_ff <= 1'b0;
    end else begin
      syn_ff <= {syn_ff[1:0], synth_pin};
      tck_ff <= {tck_ff[1:0], tick_pin};
      syn_st_ff <= (syn_ff[1] == syn_ff[2]) ? syn_ff[2] : syn_st_ff;
      tck_st_ff <= (tck_ff[1] == tck_ff[2]) ? tck_ff[2] : tck_st_ff;
    end
  end
  assign syn_p = syn_ff[1] & syn_ff[2] & ~syn_st_ff;
  assign tck_p = tck_ff[1] & tck_ff[2] & ~tck_st_ff;

  always_comb begin
    logic minor, major_div, force_maj, major, begin_obs, end_obs, take;
    logic [23:0] idx;
    logic [ADDR_W-1:0] base;
    logic [23:0] rd;
    logic [7:0] cw;
    nxt_minor_divider_hold = minor_divider_hold_ff;
    nxt_major_divider_hold = major_divider_hold_ff;
    nxt_sample_start_delay = sample_start_delay_ff;
    nxt_sample_window_end = sample_window_end_ff;
    nxt_observe_cycle_count = observe_cycle_count_ff;
    nxt_idle_cycle_count = idle_cycle_count_ff;
    nxt_addr = addr_ff;
    nxt_ptr = ptr_ff;
    nxt_inc_out = inc_out_ff;
    nxt_inc_in = inc_in_ff;
    nxt_minor_act = minor_act_ff;
    nxt_minor_cnt = minor_cnt_ff;
    nxt_major_cnt = major_cnt_ff;
    nxt_win = win_ff;
    nxt_cyc = cyc_ff;
    nxt_up = up_ff;
    nxt_first = first_ff;
    nxt_run = run_ff;
    nxt_sum = sum_ff;
    nxt_wr_pend = 1'b0;
    nxt_wa = wa_ff;
    nxt_in_word = in_word_ff;
    nxt_in_valid = 1'b0;
    nxt_done = 1'b0;
    nxt_conv = 1'b0;
    mem_we = 1'b0;
    mem_wa = addr_ff;
    mem_wd = link.out_word;
    cw = link.out_word[7:0];
    // divider counts run from the negated divisor up to all ones
    minor = syn_p && (minor_cnt_ff == 16'hffff);
    major_div = minor && (major_cnt_ff == 24'hffffff);
    force_maj = (run_ff == psi_pkg::PSI_WAIT_TICK) && tck_p;
    major = major_div || force_maj;
    if (force_maj) begin
      nxt_minor_cnt = minor_divider_hold_ff;
      nxt_major_cnt = major_divider_hold_ff;
    end else if (syn_p) begin
      // new divisors only at a major boundary keeps phase
      nxt_minor_cnt = !minor ? 16'(minor_cnt_ff + 16'h1)
                    : (major ? minor_divider_hold_ff : minor_act_ff);
      if (minor) begin
        nxt_major_cnt = major_div ? major_divider_hold_ff
                      : 24'(major_cnt_ff + 24'h1);
      end
    end
    if (major) begin
      nxt_minor_act = minor_divider_hold_ff;
    end
    // window counter: index of this minor pulse since the major
    idx = major ? 24'h0 : win_ff;
    if (minor) begin
      nxt_win = 24'(idx + 24'h1);
    end else if (major) begin
      nxt_win = 24'h0;
    end
    begin_obs = (run_ff == psi_pkg::PSI_WAIT_MAJ && major_div)
             || force_maj;
    end_obs = (run_ff == psi_pkg::PSI_OBSERVE) && major
           && (cyc_ff <= 16'h1);
    nxt_obs = begin_obs || ((run_ff == psi_pkg::PSI_OBSERVE) && !end_obs);
    // cycle counter: down while observing, up after completion
    if (run_ff == psi_pkg::PSI_OBSERVE && major) begin
      nxt_first = 1'b0;
      nxt_cyc = 16'(cyc_ff - 16'h1);
      if (end_obs) begin
        nxt_cyc = 16'h0;
        nxt_done = 1'b1;
        nxt_up = 1'b1;
        nxt_run = psi_pkg::PSI_IDLE;
      end
    end else if (run_ff == psi_pkg::PSI_IDLE && up_ff && major_div) begin
      nxt_cyc = 16'(cyc_ff + 16'h1);
    end
    if (begin_obs) begin
      nxt_run = psi_pkg::PSI_OBSERVE;
    end
    // sampling window between the two comparators
    base = major ? '0 : addr_ff;
    take = minor && nxt_obs && (idx >= sample_start_delay_ff)
        && (idx < sample_window_end_ff);
    rd = mem[base];
    if (take) begin
      nxt_sum = 24'((first_ff ? 24'h0 : rd) + sext(adc_data));
      nxt_wa = base;
      nxt_wr_pend = 1'b1;
      nxt_conv = 1'b1;
      nxt_addr = ADDR_W'(base + 1'b1);
    end else if (major && nxt_obs) begin
      nxt_addr = '0;
    end
    // host word channel
    if (link.ctl_stb) begin
      if (cw[psi_pkg::CTL_INIT]) begin
        nxt_run = psi_pkg::PSI_WAIT_TICK;
        nxt_first = 1'b1;
        nxt_idle_cycle_count = 16'h0;
      end else if (cw[psi_pkg::CTL_NEXT_CLR] || cw[psi_pkg::CTL_NEXT_KEEP]) begin
        nxt_run = psi_pkg::PSI_WAIT_MAJ;
        nxt_first = cw[psi_pkg::CTL_NEXT_CLR];
        if (up_ff) begin
          nxt_idle_cycle_count = cyc_ff;
        end
      end else begin
        nxt_ptr = cw[2:0];
        nxt_inc_out = cw[psi_pkg::CTL_INC_OUT];
        nxt_inc_in = cw[psi_pkg::CTL_INC_IN];
      end
      if (cw[psi_pkg::CTL_INIT] || cw[psi_pkg::CTL_NEXT_CLR]
          || cw[psi_pkg::CTL_NEXT_KEEP]) begin
        nxt_cyc = observe_cycle_count_ff;
        nxt_up = 1'b0;
      end
    end else if (link.out_stb || link.in_stb) begin
      if (link.out_stb) begin
        case (ptr_ff)
          psi_pkg::PTR_MINOR: nxt_minor_divider_hold = link.out_word[15:0];
          psi_pkg::PTR_MAJOR: nxt_major_divider_hold = link.out_word;
          psi_pkg::PTR_DELAY: nxt_sample_start_delay = link.out_word;
          psi_pkg::PTR_END: nxt_sample_window_end = link.out_word;
          psi_pkg::PTR_CYCLE: nxt_observe_cycle_count = link.out_word[15:0];
          psi_pkg::PTR_ADDR: nxt_addr = link.out_word[ADDR_W-1:0];
          psi_pkg::PTR_MEM: mem_we = !take;
          default: nxt_ptr = ptr_ff; // idle count is read only
        endcase
      end else begin
        // read mux onto the host word
        case (ptr_ff)
          psi_pkg::PTR_MINOR: nxt_in_word = {8'h0, minor_divider_hold_ff};
          psi_pkg::PTR_MAJOR: nxt_in_word = major_divider_hold_ff;
          psi_pkg::PTR_DELAY: nxt_in_word = sample_start_delay_ff;
          psi_pkg::PTR_END: nxt_in_word = sample_window_end_ff;
          psi_pkg::PTR_CYCLE: nxt_in_word = {8'h0, observe_cycle_count_ff};
          psi_pkg::PTR_IDLE: nxt_in_word = {8'h0, idle_cycle_count_ff};
          psi_pkg::PTR_ADDR: nxt_in_word = 24'(addr_ff);
          default: nxt_in_word = mem[addr_ff];
        endcase
        nxt_in_valid = 1'b1;
      end
      if (ptr_ff == psi_pkg::PTR_MEM) begin
        if (!take) begin
          nxt_addr = ADDR_W'(addr_ff + 1'b1);
        end
      end else if ((link.out_stb && inc_out_ff)
                || (link.in_stb && inc_in_ff)) begin
        nxt_ptr = ptr_step(ptr_ff);
      end
    end
    // accumulate write-back wins over a host memory write
    if (wr_pend_ff) begin
      mem_we = 1'b1;
      mem_wa = wa_ff;
      mem_wd = sum_ff;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      minor_divider_hold_ff <= 16'h0;
      major_divider_hold_ff <= 24'h0;
      sample_start_delay_ff <= 24'h0;
      sample_window_end_ff <= 24'h0;
      observe_cycle_count_ff <= 16'h0;
      idle_cycle_count_ff <= 16'h0;
      addr_ff <= '0;
      ptr_ff <= psi_pkg::PTR_MEM;
      inc_out_ff <= 1'b0;
      inc_in_ff <= 1'b0;
      minor_act_ff <= 16'h0;
      minor_cnt_ff <= 16'h0;
      major_cnt_ff <= 24'h0;
      win_ff <= 24'h0;
      cyc_ff <= 16'h0;
      up_ff <= 1'b0;
      first_ff <= 1'b0;
      run_ff <= psi_pkg::PSI_IDLE;
      sum_ff <= 24'h0;
      wr_pend_ff <= 1'b0;
      wa_ff <= '0;
      in_word_ff <= psi_pkg::RST_WORD;
      in_valid_ff <= 1'b0;
      done_ff <= 1'b0;
      conv_ff <= 1'b0;
      obs_ff <= 1'b0;
    end else begin
      minor_divider_hold_ff <= nxt_minor_divider_hold;
      major_divider_hold_ff <= nxt_major_divider_hold;
      sample_start_delay_ff <= nxt_sample_start_delay;
      sample_window_end_ff <= nxt_sample_window_end;
      observe_cycle_count_ff <= nxt_observe_cycle_count;
      idle_cycle_count_ff <= nxt_idle_cycle_count;
      addr_ff <= nxt_addr;
      ptr_ff <= nxt_ptr;
      inc_out_ff <= nxt_inc_out;
      inc_in_ff <= nxt_inc_in;
      minor_act_ff <= nxt_minor_act;
      minor_cnt_ff <= nxt_minor_cnt;
      major_cnt_ff <= nxt_major_cnt;
      win_ff <= nxt_win;
      cyc_ff <= nxt_cyc;
      up_ff <= nxt_up;
      first_ff <= nxt_first;
      run_ff <= nxt_run;
      sum_ff <= nxt_sum;
      wr_pend_ff <= nxt_wr_pend;
      wa_ff <= nxt_wa;
      in_word_ff <= nxt_in_word;
      in_valid_ff <= nxt_in_valid;
      done_ff <= nxt_done;
      conv_ff <= nxt_conv;
      obs_ff <= nxt_obs;
    end
  end

  assign link.in_word = in_word_ff;
  assign link.in_valid = in_valid_ff;
  assign link.done = done_ff;
  assign conv_start = conv_ff;
  assign observing = obs_ff;
endmodule

// ### logic/psi_host.sv
// host end: apb slave whose writes become control and data words
// assumes apb runs on ref_clk and the device answers reads next cycle
`timescale 1ns/100ps
module psi_host (
  input wire logic ref_clk,
  input wire logic rstn,
  psi_if.host link,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  logic ctl_ff, nxt_ctl, out_ff, nxt_out, in_ff, nxt_in;
  logic [23:0] word_ff, nxt_word, last_ff, nxt_last;
  logic done_seen_ff, nxt_done_seen, pend_ff, nxt_pend;
  logic [31:0] prdata_ff, nxt_prdata;
  logic pready_ff, nxt_pready;

  always_comb begin
    logic wr;
    wr = psel && penable && pready_ff && pwrite;
    nxt_ctl = 1'b0;
    nxt_out = 1'b0;
    nxt_in = 1'b0;
    nxt_word = word_ff;
    nxt_last = link.in_valid ? link.in_word : last_ff;
    nxt_pend = link.in_valid ? 1'b0 : pend_ff;
    nxt_done_seen = done_seen_ff;
    // zero wait state: ready rises in the first access cycle
    nxt_pready = psel && !penable;
    nxt_prdata = prdata_ff;
    if (psel && !penable) begin
      case (paddr)
        psi_pkg::APB_DIN: nxt_prdata = {8'h0, last_ff};
        psi_pkg::APB_STATUS: nxt_prdata = {30'h0, pend_ff, done_seen_ff};
        default: nxt_prdata = 32'h0;
      endcase
    end
    if (wr) begin
      case (paddr)
        psi_pkg::APB_CMD: begin
          nxt_ctl = 1'b1;
          nxt_word = pwdata[23:0];
        end
        psi_pkg::APB_DOUT: begin
          nxt_out = 1'b1;
          nxt_word = pwdata[23:0];
        end
        psi_pkg::APB_DIN: begin
          nxt_in = 1'b1;
          nxt_pend = 1'b1;
        end
        psi_pkg::APB_STATUS: begin
          if (pwdata[psi_pkg::ST_DONE]) begin
            nxt_done_seen = 1'b0;
          end
        end
        default: nxt_word = word_ff;
      endcase
    end
    // completion arriving with a clear is kept
    if (link.done) begin
      nxt_done_seen = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ctl_ff <= 1'b0;
      out_ff <= 1'b0;
      in_ff <= 1'b0;
      word_ff <= psi_pkg::RST_WORD;
      last_ff <= psi_pkg::RST_WORD;
      done_seen_ff <= 1'b0;
      pend_ff <= 1'b0;
      prdata_ff <= 32'h0;
      pready_ff <= 1'b0;
    end else begin
      ctl_ff <= nxt_ctl;
      out_ff <= nxt_out;
      in_ff <= nxt_in;
      word_ff <= nxt_word;
      last_ff <= nxt_last;
      done_seen_ff <= nxt_done_seen;
      pend_ff <= nxt_pend;
      prdata_ff <= nxt_prdata;
      pready_ff <= nxt_pready;
    end
  end

  assign link.ctl_stb = ctl_ff;
  assign link.out_stb = out_ff;
  assign link.in_stb = in_ff;
  assign link.out_word = word_ff;
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = 1'b0;
endmodule

// ### dv/psi_sva.sv
// checker for the word channel between host end and integrator end
// assumes one clock domain, ref_clk, with rstn asynchronous active low
`timescale 1ns/100ps
module psi_sva (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic ctl_stb,
  input wire logic out_stb,
  input wire logic in_stb,
  input wire logic [23:0] out_word,
  input wire logic [23:0] in_word,
  input wire logic in_valid,
  input wire logic done
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  a_in_answer: assert property (in_stb |=> in_valid)
    else $error("read request not answered next cycle");
  a_in_cause: assert property (in_valid |-> $past(in_stb))
    else $error("read word offered without a request");
  a_in_word_holds: assert property (!in_valid |-> $stable(in_word))
    else $error("read word changed without a read");
  a_in_valid_pulse: assert property (in_valid |=> !in_valid)
    else $error("read valid longer than one cycle");
  a_ctl_pulse: assert property (ctl_stb |=> !ctl_stb)
    else $error("control strobe longer than one cycle");
  a_out_alone: assert property (
    out_stb |=> !(out_stb || in_stb || ctl_stb))
    else $error("strobe follows output strobe at once");
  a_one_strobe: assert property ($onehot0({ctl_stb, out_stb, in_stb}))
    else $error("two strobes in one cycle");
  a_word_steady: assert property (
    $changed(out_word) |-> (ctl_stb || out_stb || in_stb))
    else $error("host word changed without a strobe");
  a_done_pulse: assert property (done |=> !done)
    else $error("completion pulse longer than one cycle");

  c_read: cover property (in_stb ##1 in_valid);
  c_done: cover property (done);
  c_init_start: cover property (ctl_stb && out_word[5]);
endmodule

// ### dv/tb.sv
// testbench: apb master drives the host end, pins drive the integrator
// assumes the two ends meet in psi_if and share ref_clk at 200 MHz
`timescale 1ns/100ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
  n_errors++; $display("mismatch at %0t: got %h want %h", $time, g, e); \
  end end
module tb;
  typedef struct packed {
    logic [2:0] p;
    logic [23:0] w;
    logic [23:0] e;
  } psi_row_t;
  logic ref_clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pready, pslverr, conv_start, observing;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic synth_pin = 1'b0, tick_pin = 1'b0;
  logic [11:0] adc_data = 12'h000;
  logic [2:0] syn_cnt = 3'h0;
  logic [23:0] r;
  logic [23:0] acc [4];
  int n_errors = 0, samples_checked = 0, n_conv = 0;
  // register write then two reads; widths mask the top bits
  psi_row_t rows [7] = '{
    '{3'h1, 24'habcdef, 24'h00cdef}, '{3'h2, 24'ha5a5a5, 24'ha5a5a5},
    '{3'h3, 24'h5a5a5a, 24'h5a5a5a}, '{3'h4, 24'hfedcba, 24'hfedcba},
    '{3'h5, 24'h123456, 24'h003456}, '{3'h6, 24'hffffff, 24'h000000},
    '{3'h7, 24'hffffff, 24'h001fff}};

  psi_if link();
  psi_host u_psi_host (.ref_clk(ref_clk), .rstn(rstn), .link(link.host),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  psi_device u_psi_device (.ref_clk(ref_clk), .rstn(rstn),
    .link(link.dev), .synth_pin(synth_pin), .tick_pin(tick_pin),
    .adc_data(adc_data), .conv_start(conv_start), .observing(observing));
  psi_sva chk (.ref_clk(ref_clk), .rstn(rstn), .ctl_stb(link.ctl_stb),
    .out_stb(link.out_stb), .in_stb(link.in_stb),
    .out_word(link.out_word), .in_word(link.in_word),
    .in_valid(link.in_valid), .done(link.done));

  always #2.5 ref_clk = ~ref_clk;
  // synthesizer runs free, 4 cycles high and 4 low, so pins stay legal
  always @(posedge ref_clk) begin
    syn_cnt <= syn_cnt + 3'h1;
    synth_pin <= syn_cnt[2];
    if (conv_start === 1'b1) n_conv <= n_conv + 1;
  end

  task stop_test;
    if (n_errors == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task timeout_hit;
    n_errors++;
    stop_test();
  endtask
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    `CHK(pslverr, 1'b0)
    if (k >= 20) timeout_hit();
  endtask
  task ctl(input logic [23:0] w);
    apb(1'b1, psi_pkg::APB_CMD, {8'h00, w});
  endtask
  task put(input logic [23:0] w);
    apb(1'b1, psi_pkg::APB_DOUT, {8'h00, w});
  endtask
  task wreg(input logic [2:0] p, input logic [23:0] w);
    ctl({21'h0, p});
    put(w);
  endtask
  task get(output logic [23:0] v);
    int k;
    k = 0;
    apb(1'b1, psi_pkg::APB_DIN, 32'h0);
    do begin
      apb(1'b0, psi_pkg::APB_STATUS, 32'h0);
      k++;
    end while (q[psi_pkg::ST_IN_PEND] !== 1'b0 && k < 20);
    if (k >= 20) timeout_hit();
    apb(1'b0, psi_pkg::APB_DIN, 32'h0);
    v = q[23:0];
  endtask
  // one observation; readback of words 0..3, word 3 lies past the window
  task run_obs(input logic [23:0] cmd, input logic clr,
               input logic [11:0] s);
    int k;
    logic [23:0] v;
    k = 0;
    adc_data <= s;
    n_conv = 0;
    ctl(cmd);
    if (cmd[psi_pkg::CTL_INIT]) begin
      wreg(3'h6, 24'h0);
      get(v);
      `CHK(v, 24'h0)
      repeat (300) @(posedge ref_clk);
      `CHK(n_conv, 0)
      tick_pin <= 1'b1;
      repeat (5) @(posedge ref_clk);
      tick_pin <= 1'b0;
    end
    do begin
      apb(1'b0, psi_pkg::APB_STATUS, 32'h0);
      k++;
    end while (q[psi_pkg::ST_DONE] !== 1'b1 && k < 2000);
    if (k >= 2000) timeout_hit();
    apb(1'b1, psi_pkg::APB_STATUS, 32'h1);
    `CHK(n_conv % 3 == 0 && n_conv > 0, 1'b1)
    wreg(3'h7, 24'h0);
    ctl(24'h0);
    for (int i = 0; i < 4; i++) begin
      if (i < 3)
        acc[i] = (clr ? 24'h0 : acc[i]) + 24'(n_conv / 3) * {{12{s[11]}}, s};
      get(v);
      `CHK(v, acc[i])
    end
  endtask

  initial begin
    repeat (10) @(posedge ref_clk);
    rstn <= 1'b1;
    foreach (rows[i]) begin
      wreg(rows[i].p, rows[i].w);
      get(r);
      `CHK(r, rows[i].e)
      get(r);
      `CHK(r, rows[i].e)
    end
    // step after output only: reads leave the pointer on the major hold
    ctl(24'h000009);
    put(24'h00fff0);
    get(r);
    `CHK(r, 24'ha5a5a5)
    get(r);
    `CHK(r, 24'ha5a5a5)
    ctl(24'h000014);
    get(r);
    `CHK(r, 24'hfedcba)
    get(r);
    `CHK(r, 24'h003456)
    // both modes from the address: pointer parks on memory
    ctl(24'h00001f);
    put(24'h000ffe);
    put(24'h800001);
    put(24'h7fffff);
    ctl(24'h000001);
    get(r);
    `CHK(r, 24'h00fff0)
    wreg(3'h7, 24'h000ffe);
    ctl(24'h0);
    get(r);
    `CHK(r, 24'h800001)
    get(r);
    `CHK(r, 24'h7fffff)
    apb(1'b1, 8'h10, 32'hffffffff);
    apb(1'b0, 8'h10, 32'h0);
    `CHK(q, 32'h0)
    @(posedge ref_clk);
    rstn <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rstn <= 1'b1;
    ctl(24'h000001);
    get(r);
    `CHK(r, 24'h0)
    // divide by 4 and by 8; samples at minor indices 2, 3 and 4
    wreg(3'h1, 24'h00fffc);
    wreg(3'h2, 24'hfffff8);
    wreg(3'h3, 24'h000002);
    wreg(3'h4, 24'h000005);
    wreg(3'h5, 24'h000002);
    wreg(3'h7, 24'h0);
    ctl(24'h0);
    for (int i = 0; i < 4; i++) put(24'h123456);
    acc[3] = 24'h123456;
    run_obs(24'h000020, 1'b1, 12'hffd);
    run_obs(24'h000080, 1'b0, 12'h7ff);
    run_obs(24'h000040, 1'b1, 12'h005);
    run_obs(24'h000020, 1'b1, 12'h801);
    stop_test();
  end
endmodule
